/* src/vam_monitor.sv */
/*
 * vam_monitor: serial-bus slave, converter sequencer, averaging, limit check and alert.
 * Assumes an external SAR comparator/DAC and open-drain pads resolved outside.
 */
// Function
// - answer alert response read with own address
// - lose arbitration: withdraw, keep alert pending
// - alert releases only at status read, condition gone
// - idle 35 ms: drop transfer, release lines
// - config1 bit 6 set disables timeout
// - one multiplexed SAR converter, 10-bit code
// - nominal input gives code 0x300
// - 711 us per conversion, sixteen averaged
// - averaged mode stores only the mean
// - core reading outside limits sets status
// - config2 bit 4 turns averaging off
// - config2 bit 5 bypasses core attenuator
// - config2 bit 6 selects single-channel mode
// - channel chosen by bits 7:5 of 0x55
// - respond to fixed address 0101110, and to alert response read while alert pending
`timescale 1ns/1ns
`default_nettype none
module vam_monitor #(
	parameter int unsigned CONV_CYCLES = vam_pkg::CONV_CYC,
	parameter int unsigned TIMEOUT_CYCLES = vam_pkg::TIMEOUT_CYC
) (
	input wire logic i_ref_clk, // 100 MHz core clock
	input wire logic i_rstn, // synchronous reset, active low
	input wire logic i_scl, // bus clock pin, also link clock
	input wire logic i_sda, // bus data pin level
	output logic o_sda_oe, // pull data line low
	output logic o_scl_oe, // pull clock line low (never)
	output logic o_alert_oe, // pull shared alert line low
	input wire logic i_sar_cmp, // comparator: input above trial code
	output logic [9:0] o_sar_code, // trial code to the converter DAC
	output logic [2:0] o_mux_sel, // analog multiplexer channel
	output logic o_atten_bypass // core input attenuator removed
);
	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_ADDR = 6'b000010,
		ST_WPTR = 6'b000100,
		ST_WDATA = 6'b001000,
		ST_READ = 6'b010000,
		ST_ARA = 6'b100000
	} vam_state_t;
	localparam int unsigned STEP_CYCLES = CONV_CYCLES / (vam_pkg::ADC_BITS + 1);

	// ------------------------------------------------------------
	// link clock domain: bus clock edges become a toggle
	// ------------------------------------------------------------
	logic lk_rst_s1, lk_rst_s2, act_tgl_r;
	// reset is brought over on the bus clock itself; it only matters once edges run
	always_ff @(posedge i_scl) begin
		lk_rst_s1 <= i_rstn;
		lk_rst_s2 <= lk_rst_s1;
	end
	always_ff @(posedge i_scl) begin
		if (!lk_rst_s2) act_tgl_r <= 1'b0;
		else act_tgl_r <= ~act_tgl_r;
	end

	// ------------------------------------------------------------
	// synchronisers into the reference domain
	// ------------------------------------------------------------
	logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
	logic tgl_s1, tgl_s2, tgl_s3, cmp_s1, cmp_s2;
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			{scl_s1, scl_s2, scl_s3} <= 3'h7;
			{sda_s1, sda_s2, sda_s3} <= 3'h7;
			{tgl_s1, tgl_s2, tgl_s3} <= 3'h0;
			{cmp_s1, cmp_s2} <= 2'h0;
		end else begin
			{scl_s1, scl_s2, scl_s3} <= {i_scl, scl_s1, scl_s2};
			{sda_s1, sda_s2, sda_s3} <= {i_sda, sda_s1, sda_s2};
			{tgl_s1, tgl_s2, tgl_s3} <= {act_tgl_r, tgl_s1, tgl_s2};
			{cmp_s1, cmp_s2} <= {i_sar_cmp, cmp_s1};
		end
	end
	logic scl_rise, scl_fall, bus_start, bus_stop, bus_act;
	assign scl_rise = scl_s2 & ~scl_s3;
	assign scl_fall = ~scl_s2 & scl_s3;
	assign bus_start = scl_s2 & scl_s3 & ~sda_s2 & sda_s3;
	assign bus_stop = scl_s2 & scl_s3 & sda_s2 & ~sda_s3;
	// clock edges also seen directly, as the toggle only resets once the bus clock runs
	assign bus_act = (tgl_s2 ^ tgl_s3) | (scl_s2 ^ scl_s3) | (sda_s2 ^ sda_s3);

	// ------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------
	logic [7:0] core_r, supply_r, cfg1_r, cfg2_r, chsel_r, low_r, high_r, ptr_r;
	logic [1:0] status_r, live_r;
	logic alert_r, wr_stb_r, stat_rd_r, core_new, tmo_hit, lost;
	logic [7:0] rx_r, tx_r, rd_data;
	logic [3:0] cnt_r;
	logic first_r, mack_r, sda_oe_r;
	vam_state_t state_r;
	logic xmit;
	assign xmit = (state_r == ST_READ) || (state_r == ST_ARA);

	// read multiplexer; unmapped offsets read as zero
	always_comb begin
		unique case (ptr_r)
			vam_pkg::REG_CORE: rd_data = core_r;
			vam_pkg::REG_SUPPLY: rd_data = supply_r;
			vam_pkg::REG_CFG1: rd_data = cfg1_r;
			vam_pkg::REG_STATUS: rd_data = {6'h00, status_r};
			vam_pkg::REG_LOW: rd_data = low_r;
			vam_pkg::REG_HIGH: rd_data = high_r;
			vam_pkg::REG_CHSEL: rd_data = chsel_r;
			vam_pkg::REG_CFG2: rd_data = cfg2_r;
			default: rd_data = 8'h00;
		endcase
	end

	// ------------------------------------------------------------
	// bus-idle timeout
	// ------------------------------------------------------------
	logic [31:0] tmo_cnt_r;
	// counts only while a transfer is open, so an idle bus never trips it
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn || bus_act || state_r == ST_IDLE) tmo_cnt_r <= 32'h0;
		else if (!tmo_hit) tmo_cnt_r <= tmo_cnt_r + 32'h1;
	end
	assign tmo_hit = !cfg1_r[vam_pkg::BUS_TIMEOUT_DISABLE_BIT] && (state_r != ST_IDLE)
		&& (tmo_cnt_r >= TIMEOUT_CYCLES - 1);
	// we drive a one where the line reads zero: another slave has a lower address
	assign lost = xmit && scl_rise && (cnt_r < 4'h8) && !sda_oe_r && !sda_s2;

	// ------------------------------------------------------------
	// slave state machine
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			state_r <= ST_IDLE;
			cnt_r <= 4'h0;
			rx_r <= 8'h00;
			tx_r <= 8'h00;
			ptr_r <= 8'h00;
			first_r <= 1'b0;
			mack_r <= 1'b0;
			sda_oe_r <= 1'b0;
			wr_stb_r <= 1'b0;
			stat_rd_r <= 1'b0;
		end else begin
			wr_stb_r <= 1'b0;
			stat_rd_r <= 1'b0;
			if (tmo_hit || lost || bus_stop) begin
				state_r <= ST_IDLE;
				sda_oe_r <= 1'b0;
			end else if (bus_start) begin
				state_r <= ST_ADDR;
				cnt_r <= 4'h0;
				sda_oe_r <= 1'b0;
			end else if (state_r != ST_IDLE && scl_rise) begin
				if (cnt_r < 4'h8) rx_r <= {rx_r[6:0], sda_s2};
				if (cnt_r == 4'h8) mack_r <= ~sda_s2;
				cnt_r <= cnt_r + 4'h1;
			end else if (state_r != ST_IDLE && scl_fall) begin
				if (cnt_r == 4'h8) begin
					unique case (state_r)
						ST_ADDR: begin
							if (rx_r[7:1] == vam_pkg::SLAVE_ADDR) begin
								sda_oe_r <= 1'b1;
								first_r <= 1'b1;
								state_r <= rx_r[0] ? ST_READ : ST_WPTR;
							end else if (rx_r == {vam_pkg::ARA_ADDR, 1'b1} && alert_r) begin
								sda_oe_r <= 1'b1;
								first_r <= 1'b1;
								state_r <= ST_ARA;
							end else begin
								state_r <= ST_IDLE;
							end
						end
						ST_WPTR: begin
							ptr_r <= rx_r;
							sda_oe_r <= 1'b1;
							state_r <= ST_WDATA;
						end
						ST_WDATA: begin
							wr_stb_r <= 1'b1;
							sda_oe_r <= 1'b1;
						end
						default: sda_oe_r <= 1'b0; // master owns the ack slot
					endcase
				end else if (cnt_r == 4'h9) begin
					cnt_r <= 4'h0;
					first_r <= 1'b0;
					if (xmit && (first_r || mack_r)) begin
						// answer to the alert response is our address, write bit low
						tx_r <= (state_r == ST_ARA) ? {vam_pkg::SLAVE_ADDR, 1'b0} : rd_data;
						sda_oe_r <= (state_r == ST_ARA) ? ~vam_pkg::SLAVE_ADDR[6] : ~rd_data[7];
						stat_rd_r <= (state_r == ST_READ) && (ptr_r == vam_pkg::REG_STATUS);
						if (state_r == ST_ARA && !first_r) state_r <= ST_IDLE;
					end else begin
						sda_oe_r <= 1'b0;
						if (xmit) state_r <= ST_IDLE;
					end
				end else if (xmit && cnt_r != 4'h0) begin
					tx_r <= {tx_r[6:0], 1'b0};
					sda_oe_r <= ~tx_r[6];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// writable registers
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			cfg1_r <= vam_pkg::RST_CFG;
			cfg2_r <= vam_pkg::RST_CFG;
			chsel_r <= vam_pkg::RST_CFG;
			low_r <= vam_pkg::RST_LOW;
			high_r <= vam_pkg::RST_HIGH;
		end else if (wr_stb_r) begin
			if (ptr_r == vam_pkg::REG_CFG1) cfg1_r <= rx_r;
			if (ptr_r == vam_pkg::REG_CFG2) cfg2_r <= rx_r;
			if (ptr_r == vam_pkg::REG_CHSEL) chsel_r <= rx_r;
			if (ptr_r == vam_pkg::REG_LOW) low_r <= rx_r;
			if (ptr_r == vam_pkg::REG_HIGH) high_r <= rx_r;
		end
	end

	// ------------------------------------------------------------
	// conversion timing and successive approximation
	// ------------------------------------------------------------
	logic [31:0] conv_cnt_r, step_cnt_r;
	logic [3:0] bit_r;
	logic conv_done_r, sar_busy_r, scan_ch_r;
	vam_pkg::vam_conv_mode_t mode_r;
	logic [9:0] result_r;
	logic conv_start;
	assign conv_start = (conv_cnt_r == 32'h0);
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn || conv_cnt_r >= CONV_CYCLES - 1) conv_cnt_r <= 32'h0;
		else conv_cnt_r <= conv_cnt_r + 32'h1;
	end
	// settings are sampled only here, so a write lands on the next conversion
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			mode_r <= '0;
		end else if (conv_start) begin
			mode_r.ch <= cfg2_r[vam_pkg::SINGLE_BIT]
				? chsel_r[vam_pkg::CHSEL_MSB:vam_pkg::CHSEL_LSB]
				: (scan_ch_r ? vam_pkg::CH_SUPPLY : vam_pkg::CH_CORE);
			mode_r.avg_off <= cfg2_r[vam_pkg::AVGOFF_BIT];
			mode_r.bypass <= cfg2_r[vam_pkg::BYPASS_BIT];
		end
	end
	// one bit decided per step, MSB first; the DAC spans 0x300 at nominal input
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			o_sar_code <= 10'h000;
			bit_r <= 4'h0;
			step_cnt_r <= 32'h0;
			sar_busy_r <= 1'b0;
			conv_done_r <= 1'b0;
			result_r <= 10'h000;
		end else begin
			conv_done_r <= 1'b0;
			if (conv_start) begin
				o_sar_code <= vam_pkg::SAR_FIRST;
				bit_r <= 4'h9;
				step_cnt_r <= 32'h0;
				sar_busy_r <= 1'b1;
			end else if (sar_busy_r && step_cnt_r >= STEP_CYCLES - 1) begin
				step_cnt_r <= 32'h0;
				o_sar_code[bit_r] <= cmp_s2;
				if (bit_r != 4'h0) o_sar_code[bit_r - 4'h1] <= 1'b1;
				else sar_busy_r <= 1'b0;
				bit_r <= bit_r - 4'h1;
			end else if (sar_busy_r) begin
				step_cnt_r <= step_cnt_r + 32'h1;
			end
			if (conv_cnt_r == CONV_CYCLES - 1) begin
				conv_done_r <= 1'b1;
				result_r <= o_sar_code;
			end
		end
	end

	// ------------------------------------------------------------
	// averaging and value registers
	// ------------------------------------------------------------
	logic [13:0] acc_r, acc_sum;
	logic [3:0] avg_n_r;
	logic [2:0] acc_ch_r;
	logic val_wr;
	logic [9:0] val_code;
	assign acc_sum = ((acc_ch_r == mode_r.ch) ? acc_r : 14'h0000) + {4'h0, result_r};
	assign val_wr = conv_done_r && (mode_r.avg_off || avg_n_r == vam_pkg::AVG_LAST);
	assign val_code = mode_r.avg_off ? result_r : acc_sum[13:vam_pkg::AVG_SHIFT];
	assign core_new = val_wr && (mode_r.ch == vam_pkg::CH_CORE);
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			acc_r <= 14'h0000;
			avg_n_r <= 4'h0;
			acc_ch_r <= vam_pkg::CH_CORE;
		end else if (conv_done_r) begin
			acc_ch_r <= mode_r.ch;
			acc_r <= val_wr ? 14'h0000 : acc_sum;
			avg_n_r <= (val_wr || acc_ch_r != mode_r.ch) ? {3'h0, !val_wr} : avg_n_r + 4'h1;
		end
	end
	// temperature channels convert but their results are not stored
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			core_r <= vam_pkg::RST_READING;
			supply_r <= vam_pkg::RST_READING;
			scan_ch_r <= 1'b0;
		end else if (val_wr) begin
			if (mode_r.ch == vam_pkg::CH_CORE) core_r <= val_code[9:2];
			if (mode_r.ch == vam_pkg::CH_SUPPLY) supply_r <= val_code[9:2];
			scan_ch_r <= ~scan_ch_r;
		end
	end

	// ------------------------------------------------------------
	// limit check, status and alert
	// ------------------------------------------------------------
	logic [1:0] cmp_now;
	assign cmp_now = {val_code[9:2] > high_r, val_code[9:2] < low_r};
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			live_r <= 2'h0;
			status_r <= 2'h0;
		end else begin
			if (core_new) live_r <= cmp_now;
			// a read keeps only what still holds; a fresh breach wins over the read
			if (stat_rd_r) status_r <= live_r | (core_new ? cmp_now : 2'h0);
			else if (core_new) status_r <= status_r | cmp_now;
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			alert_r <= 1'b0;
			o_mux_sel <= vam_pkg::CH_CORE;
			o_atten_bypass <= 1'b0;
			o_scl_oe <= 1'b0;
		end else begin
			alert_r <= |status_r;
			o_mux_sel <= mode_r.ch;
			o_atten_bypass <= mode_r.bypass;
			o_scl_oe <= 1'b0; // clock is never stretched
		end
	end
	assign o_sda_oe = sda_oe_r;
	assign o_alert_oe = alert_r;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);
	ara_answer_a: assert property (state_r == ST_ADDR && scl_fall && cnt_r == 4'h8 && !bus_stop
		&& !tmo_hit && rx_r == {vam_pkg::ARA_ADDR, 1'b1} && alert_r |=> sda_oe_r && state_r == ST_ARA)
		else $error("alert response not acknowledged");
	arb_withdraw_a: assert property (lost |=> state_r == ST_IDLE && !sda_oe_r
		&& $stable(status_r)) else $error("arbitration loss not handled");
	alert_release_a: assert property ($fell(status_r[0] | status_r[1]) |-> $past(stat_rd_r))
		else $error("alert cleared without status read");
	timeout_drop_a: assert property (tmo_hit |=> state_r == ST_IDLE ##1 !o_sda_oe)
		else $error("timeout did not release bus");
	timeout_off_a: assert property (cfg1_r[vam_pkg::BUS_TIMEOUT_DISABLE_BIT] |-> !tmo_hit)
		else $error("timeout fired while disabled");
	conv_space_a: assert property (conv_done_r |=> !conv_done_r [*8])
		else $error("conversions too close");
	mean_only_a: assert property (conv_done_r && !mode_r.avg_off && avg_n_r != vam_pkg::AVG_LAST
		|=> $stable(core_r) && $stable(supply_r))
		else $error("value written with a single sample");
	high_flag_a: assert property (core_new && val_code[9:2] > high_r |=> status_r[1] ##1 alert_r)
		else $error("high breach not flagged");
	single_sel_a: assert property (conv_start && cfg2_r[vam_pkg::SINGLE_BIT]
		|=> mode_r.ch == $past(chsel_r[7:5])) else $error("single channel not selected");
	own_addr_a: assert property (state_r == ST_ADDR && scl_fall && cnt_r == 4'h8 && !bus_start
		&& rx_r[7:1] != vam_pkg::SLAVE_ADDR && rx_r[7:1] != vam_pkg::ARA_ADDR |=> !sda_oe_r)
		else $error("foreign address acknowledged");
	ara_done_c: cover property (state_r == ST_ARA && stat_rd_r == 1'b0 ##1 state_r == ST_IDLE);
	write_c: cover property (wr_stb_r && ptr_r == vam_pkg::REG_CFG2);
	mean_c: cover property (core_new && !mode_r.avg_off);
	timeout_c: cover property (tmo_hit);
endmodule // vam_monitor
`default_nettype wire

/* src/vam_pkg.sv */
/*
 * vam_pkg: constants and carrier types of the voltage monitor with alert.
 * Assumes a 100 MHz reference clock; times below are converted to cycles here.
 */
package vam_pkg;
	// ------------------------------------------------------------
	// serial bus addresses
	// ------------------------------------------------------------
	localparam logic [6:0] SLAVE_ADDR = 7'h2E;
	localparam logic [6:0] ARA_ADDR = 7'h0C;
	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CORE = 8'h21;
	localparam logic [7:0] REG_SUPPLY = 8'h22;
	localparam logic [7:0] REG_CFG1 = 8'h40;
	localparam logic [7:0] REG_STATUS = 8'h41;
	localparam logic [7:0] REG_LOW = 8'h46;
	localparam logic [7:0] REG_HIGH = 8'h47;
	localparam logic [7:0] REG_CHSEL = 8'h55;
	localparam logic [7:0] REG_CFG2 = 8'h73;
	// ------------------------------------------------------------
	// reset values and field positions
	// ------------------------------------------------------------
	localparam logic [7:0] RST_READING = 8'h00;
	localparam logic [7:0] RST_LOW = 8'h00;
	localparam logic [7:0] RST_HIGH = 8'hFF;
	localparam logic [7:0] RST_CFG = 8'h00;
	localparam int BUS_TIMEOUT_DISABLE_BIT = 6;
	localparam int AVGOFF_BIT = 4;
	localparam int BYPASS_BIT = 5;
	localparam int SINGLE_BIT = 6;
	localparam int CHSEL_MSB = 7;
	localparam int CHSEL_LSB = 5;
	localparam int STAT_LOW_BIT = 0;
	localparam int STAT_HIGH_BIT = 1;
	// ------------------------------------------------------------
	// converter channels and scaling
	// ------------------------------------------------------------
	localparam logic [2:0] CH_CORE = 3'h1;
	localparam logic [2:0] CH_SUPPLY = 3'h2;
	localparam logic [2:0] CH_REM1 = 3'h5;
	localparam logic [2:0] CH_LOCAL = 3'h6;
	localparam logic [2:0] CH_REM2 = 3'h7;
	localparam int ADC_BITS = 10;
	localparam logic [3:0] AVG_LAST = 4'hF; // sixteen samples per mean
	localparam int AVG_SHIFT = 4;
	localparam logic [9:0] NOMINAL_CODE = 10'h300; // three quarters of full scale
	localparam logic [9:0] SAR_FIRST = 10'h200;
	// ------------------------------------------------------------
	// timing (11.38 ms measurement = sixteen conversions)
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int CONV_TIME_NS = 711_000;
	localparam int TIMEOUT_TIME_MS = 35;
	localparam int CONV_CYC = CONV_TIME_NS / CLK_PERIOD_NS;
	localparam int TIMEOUT_CYC = TIMEOUT_TIME_MS * 1_000_000 / CLK_PERIOD_NS;
	// ------------------------------------------------------------
	// carrier: conversion settings latched at conversion start
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0] ch;
		logic avg_off;
		logic bypass;
	} vam_conv_mode_t;
endpackage

/* bench/vam_smb_master.sv */
/*
 * vam_smb_master: behavioural serial bus master for the monitor bench.
 * Assumes a pull-up on the data line; the clock line is driven by this model only.
 */
`timescale 1ns/1ns
`default_nettype none
module vam_smb_master (
	input wire logic i_sda, // resolved data line
	output logic o_scl, // bus clock, still between frames
	output logic o_sda_low // pull data line low
);
	// ----------------------------------------
	// bus cycles, 125 ns per bit
	// ----------------------------------------
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end
	// change data while clock low, sample mid-high so slave delays fit
	task automatic bit_io(input logic b, output logic r);
		#31 o_sda_low = ~b;
		#31 o_scl = 1'b1;
		#31 r = i_sda;
		#32 o_scl = 1'b0;
	endtask
	// start or repeated start
	task automatic start();
		#31 o_sda_low = 1'b0;
		#31 o_scl = 1'b1;
		#62 o_sda_low = 1'b1;
		#63 o_scl = 1'b0;
	endtask
	// stop leaves both lines released
	task automatic stop();
		#31 o_sda_low = 1'b1;
		#31 o_scl = 1'b1;
		#62 o_sda_low = 1'b0;
	endtask
	// msb first, then the ack slot with the line released
	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], r);
		end
		bit_io(1'b1, ack);
	endtask
	// pull holds bits low as a rival sender would; nack ends the read
	task automatic get_byte(input logic [7:0] pull, input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(~pull[i], d[i]);
		end
		bit_io(nack, r);
	endtask
endmodule // vam_smb_master
`default_nettype wire

/* bench/vam_monitor_tb.sv */
/*
 * vam_monitor_tb: self-checking bench for the voltage monitor with alert.
 * Assumes vam_monitor and vam_smb_master are compiled; comparator is modelled here.
 */
`timescale 1ns/1ns
`default_nettype none
module vam_monitor_tb;
	// ----------------------------------------
	// stimulus, models and checks
	// ----------------------------------------
	localparam int CONV = 220;
	localparam int TMO = 500;
	typedef struct packed {logic [7:0] a; logic w; logic [7:0] v; logic [7:0] e;} vam_row_t;
	localparam vam_row_t ROWS [0:10] = '{{8'h21, 1'b0, 8'h00, 8'h00},
		{8'h22, 1'b0, 8'h00, 8'h00}, {8'h46, 1'b0, 8'h00, 8'h00}, {8'h47, 1'b0, 8'h00, 8'hFF},
		{8'h40, 1'b0, 8'h00, 8'h00}, {8'h55, 1'b0, 8'h00, 8'h00}, {8'h73, 1'b0, 8'h00, 8'h00},
		{8'h30, 1'b0, 8'h00, 8'h00}, {8'h46, 1'b1, 8'h5A, 8'h5A}, {8'h55, 1'b1, 8'hE0, 8'hE0},
		{8'h47, 1'b1, 8'hFF, 8'hFF}};
	localparam logic [2:0] CHS [0:4] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic sar_cmp = 1'b0;
	logic [10:0] v_core = 11'h601; // odd half steps never tie a trial code
	logic [10:0] v_sup = 11'h401;
	logic seen_c = 1'b0;
	logic seen_s = 1'b0;
	logic scl, sda_low, sda_oe, scl_oe, alert, bypass, ack;
	logic [9:0] code;
	logic [2:0] mux;
	logic [7:0] d;
	wire logic sda;
	int err_count = 0;
	int checks = 0;
	assign sda = ~(sda_low | sda_oe); // pull-up resolves the open-drain line
	always #5 clk = ~clk;
	// comparator and scan watch; only core and supply carry real levels
	always @(posedge clk) begin
		sar_cmp <= ((mux == 3'h1) ? v_core : (mux == 3'h2) ? v_sup : 11'h101) > {code, 1'b0};
		seen_c <= seen_c | (mux === 3'h1);
		seen_s <= seen_s | (mux === 3'h2);
	end
	vam_monitor #(.CONV_CYCLES(CONV), .TIMEOUT_CYCLES(TMO)) vam_monitor_i (.i_ref_clk(clk),
		.i_rstn(rstn), .i_scl(scl), .i_sda(sda), .o_sda_oe(sda_oe), .o_scl_oe(scl_oe),
		.o_alert_oe(alert), .i_sar_cmp(sar_cmp), .o_sar_code(code), .o_mux_sel(mux),
		.o_atten_bypass(bypass));
	vam_smb_master vam_smb_master_i (.i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		vam_smb_master_i.start();
		vam_smb_master_i.put_byte(8'h5C, ack);
		cmp8({7'h00, ack}, 8'h00);
		vam_smb_master_i.put_byte(a, ack);
		vam_smb_master_i.put_byte(v, ack);
		vam_smb_master_i.stop();
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		vam_smb_master_i.start();
		vam_smb_master_i.put_byte(8'h5C, ack);
		vam_smb_master_i.put_byte(a, ack);
		vam_smb_master_i.start();
		vam_smb_master_i.put_byte(8'h5D, ack);
		cmp8({7'h00, ack}, 8'h00);
		vam_smb_master_i.get_byte(8'h00, 1'b1, v);
		vam_smb_master_i.stop();
	endtask
	// read from the alert response address, never used as a slave address
	task automatic ara(input logic [7:0] pull, output logic [7:0] v);
		vam_smb_master_i.start();
		vam_smb_master_i.put_byte(8'h19, ack);
		vam_smb_master_i.get_byte(pull, 1'b1, v);
		vam_smb_master_i.stop();
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// hang guard: a stuck run still reaches the verdict
	initial begin
		repeat (100000) @(posedge clk);
		err_count++;
		tally_and_finish();
	end
	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		foreach (ROWS[i]) begin
			if (ROWS[i].w) begin
				wr(ROWS[i].a, ROWS[i].v);
			end
			rd(ROWS[i].a, d);
			cmp8(d, ROWS[i].e);
		end
		$display("test registers done");
		// forty conversions: at least one full averaged measurement per input
		repeat (40 * CONV) @(posedge clk);
		rd(8'h21, d);
		cmp8(d, 8'hC0);
		rd(8'h22, d);
		cmp8(d, 8'h80);
		cmp8({6'h00, seen_c, seen_s}, 8'h03);
		$display("test averaging done");
		wr(8'h47, 8'hB0);
		repeat (40 * CONV) @(posedge clk);
		cmp8({7'h00, alert}, 8'h01);
		ara(8'h40, d);
		cmp8(d, 8'h3F);
		cmp8({7'h00, alert}, 8'h01);
		ara(8'h00, d);
		cmp8({7'h00, ack}, 8'h00);
		cmp8(d, 8'h5C);
		rd(8'h41, d);
		cmp8(d & 8'h02, 8'h02);
		cmp8({7'h00, alert}, 8'h01);
		wr(8'h47, 8'hFF);
		repeat (40 * CONV) @(posedge clk);
		rd(8'h41, d);
		repeat (4) @(posedge clk);
		cmp8({7'h00, alert}, 8'h00);
		ara(8'h00, d);
		cmp8({7'h00, ack}, 8'h01);
		vam_smb_master_i.start();
		vam_smb_master_i.put_byte(8'h5E, ack);
		vam_smb_master_i.stop();
		cmp8({7'h00, ack}, 8'h01);
		$display("test alert done");
		wr(8'h55, 8'h40);
		wr(8'h73, 8'h70);
		@(posedge clk);
		v_sup <= 11'h201;
		repeat (3 * CONV) @(posedge clk);
		cmp8({5'h00, mux}, 8'h02);
		cmp8({7'h00, bypass}, 8'h01);
		wr(8'h22, 8'hFF);
		rd(8'h22, d);
		cmp8(d, 8'h40);
		foreach (CHS[i]) begin
			wr(8'h55, {CHS[i], 5'h00});
			repeat (3 * CONV) @(posedge clk);
			cmp8({5'h00, mux}, {5'h00, CHS[i]});
		end
		$display("test single channel done");
		// stall the clock low while the slave holds its ack
		for (int k = 0; k < 2; k++) begin
			wr(8'h40, (k == 0) ? 8'h40 : 8'h00);
			vam_smb_master_i.start();
			for (int i = 7; i >= 0; i--) begin
				vam_smb_master_i.bit_io(i inside {6, 4, 3, 2}, ack);
			end
			repeat (TMO - 50) @(posedge clk);
			cmp8({7'h00, sda_oe}, 8'h01);
			repeat (150) @(posedge clk);
			cmp8({7'h00, sda_oe}, {7'h00, k == 0});
			vam_smb_master_i.bit_io(1'b1, ack);
			vam_smb_master_i.stop();
		end
		$display("test timeout done");
		// mid-run reset must bring the settings back to their defaults
		@(posedge clk);
		rstn <= 1'b0;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		rd(8'h73, d);
		cmp8(d, 8'h00);
		cmp8({7'h00, alert}, 8'h00);
		$display("test reset done");
		tally_and_finish();
	end
endmodule // vam_monitor_tb
`default_nettype wire
